// >>> core/bscc_pkg.sv
package bscc_pkg;

  // Register offsets, byte addresses on the Wishbone bus
  localparam logic [7:0] BSCC_FCR_OFS = 8'h00;
  localparam logic [7:0] BSCC_BPREG_OFS = 8'h04;
  localparam logic [7:0] BSCC_COUNT_OFS = 8'h08;
  localparam logic [7:0] BSCC_EVENT_OFS = 8'h0c;

  // Values after reset
  localparam logic [31:0] BSCC_FCR_RST = 32'h0000_0000;
  localparam logic [12:0] BSCC_BPREG_RST = 13'h0000;
  localparam logic [5:0] BSCC_COUNT_RST = 6'h00;
  localparam logic [4:0] BSCC_BITPOS_RST = 5'h00;

  // Field positions inside the function control register
  localparam int BSCC_FCR_COND_LO = 16;
  localparam int BSCC_FCR_COND_HI = 17;
  localparam int BSCC_FCR_INT_INSTEAD = 18;
  localparam int BSCC_FCR_MICRO_SEL = 19;

  // Field positions inside the count status word
  localparam int BSCC_CNT_LOW2_POS = 8;
  localparam int BSCC_CNT_LOW4_POS = 9;
  localparam int BSCC_CNT_LOW5Z_POS = 10;
  localparam int BSCC_CNT_ALLZ_POS = 11;
  localparam int BSCC_CNT_MATCH_POS = 12;
  localparam int BSCC_CNT_BITPOS_POS = 16;

  // Field positions inside the event word
  localparam int BSCC_EV_MACRO_INT_POS = 0;
  localparam int BSCC_EV_HOLD_POS = 1;
  localparam int BSCC_EV_RUN_POS = 2;
  localparam int BSCC_EV_JOINT_POS = 3;

  // Timing
  localparam int BSCC_CLK_PERIOD_NS = 100;
  localparam int BSCC_OSC_PERIOD_NS = 120;
  localparam int BSCC_OSC_CYCLES = (BSCC_OSC_PERIOD_NS / BSCC_CLK_PERIOD_NS) < 1 ? 1 :
                                   (BSCC_OSC_PERIOD_NS / BSCC_CLK_PERIOD_NS);
  localparam int BSCC_RESTART_MS = 15;
  localparam int BSCC_RESTART_CYCLES = (BSCC_RESTART_MS * 1000000 + BSCC_CLK_PERIOD_NS - 1) / BSCC_CLK_PERIOD_NS;

  // Breakpoint condition codes
  localparam logic [1:0] BSCC_BP_OFF = 2'h0;
  localparam logic [1:0] BSCC_BP_FETCH = 2'h1;
  localparam logic [1:0] BSCC_BP_STORE = 2'h2;
  localparam logic [1:0] BSCC_BP_ANY = 2'h3;

  typedef enum logic [1:0] {
    BSCC_CLK_STOPPED,
    BSCC_CLK_RUN,
    BSCC_CLK_HOLD,
    BSCC_CLK_JOINT
  } bscc_clk_state_e;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] addr;
    logic word_sel;
  } bscc_micro_addr_s;

  typedef struct packed {
    logic low2_ones;
    logic low4_ones;
    logic low5_zero;
    logic all_zero;
  } bscc_jump_s;

endpackage : bscc_pkg

// >>> core/bscc_tick_div.sv
`timescale 1ns/1ns
module bscc_tick_div #(
  parameter int DIV = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  localparam int CW = DIV > 1 ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt;
  wire at_last = (cnt == LAST);

  // Counter restarts from zero whenever the run gate drops, so each restart is a full period
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else begin
      cnt <= at_last ? '0 : cnt + CW'(1);
      tick_o <= at_last;
    end
  end
endmodule : bscc_tick_div

// >>> core/bscc_core.sv
// The implementer's own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module bscc_core #(
  parameter int RESTART_CYCLES = bscc_pkg::BSCC_RESTART_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_stb_i,
  input wire logic wb_cyc_i,
  output logic wb_ack_o,
  input wire logic master_clear_i,
  input wire logic count_preset_strobe_i,
  input wire logic count_clear_strobe_i,
  input wire logic count_enable_i,
  input wire logic [5:0] instr_count_i,
  input wire logic [4:0] shift_reg_low_i,
  input wire logic bitpos_load_i,
  input wire logic digit_mode_i,
  input wire logic controller_owns_processor_i,
  input wire bscc_pkg::bscc_micro_addr_s micro_addr_i,
  input wire logic [11:0] macro_addr_i,
  input wire logic instr_fetch_i,
  input wire logic operand_store_i,
  input wire logic local_mode_i,
  input wire logic key_press_strobe_i,
  input wire logic processor_phase_clock_i,
  output bscc_pkg::bscc_jump_s jump_o,
  output logic [5:0] count_o,
  output logic [4:0] bitpos_o,
  output logic bitpos_match_o,
  output logic macro_stop_o,
  output logic micro_stop_o,
  output logic macro_bp_interrupt_status_o,
  output logic ctl_clk_en_o
);
  import bscc_pkg::*;

  localparam int RW = $clog2(RESTART_CYCLES + 1);
  localparam logic [RW-1:0] RESTART_LAST = RW'(RESTART_CYCLES - 1);

  logic [31:0] function_control_register;
  logic [12:0] bp_reg;
  logic [5:0] count;
  logic [4:0] bitpos;
  logic macro_int;
  logic hold;
  logic [RW-1:0] restart_cnt;
  logic phase_q;
  logic ack;
  logic [31:0] rdata;
  bscc_clk_state_e clk_state;
  bscc_clk_state_e next_clk_state;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] val,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = val[8*i +: 8];
      end
    end
    return r;
  endfunction : merge_bytes

  // Bus decode
  wire bus_req = wb_cyc_i && wb_stb_i && !ack;
  wire bus_wr = bus_req && wb_we_i;
  wire wr_fcr = bus_wr && (wb_adr_i == BSCC_FCR_OFS);
  wire wr_bp = bus_wr && (wb_adr_i == BSCC_BPREG_OFS);
  wire wr_event = bus_wr && (wb_adr_i == BSCC_EVENT_OFS) && wb_sel_i[0];
  wire [31:0] fcr_merged = merge_bytes(function_control_register, wb_dat_i, wb_sel_i);
  wire [31:0] bp_merged = merge_bytes({19'h00000, bp_reg}, wb_dat_i, wb_sel_i);

  // Loose control bits
  wire micro_mode = function_control_register[BSCC_FCR_MICRO_SEL];
  wire bp_condition_low = function_control_register[BSCC_FCR_COND_LO];
  wire bp_condition_high = function_control_register[BSCC_FCR_COND_HI];
  wire bp_interrupt_instead = function_control_register[BSCC_FCR_INT_INSTEAD];
  wire [1:0] bp_cond = {bp_condition_high, bp_condition_low};
  wire mclr = rst_i || master_clear_i;

  // Controller clock
  wire osc_tick;
  wire phase_rise = processor_phase_clock_i && !phase_q;
  wire joint = controller_owns_processor_i;
  wire osc_run = (clk_state == BSCC_CLK_RUN);
  wire restart_end = hold && (restart_cnt == RESTART_LAST);
  wire ctl_tick = joint ? phase_rise : osc_tick;

  bscc_tick_div #(
    .DIV(BSCC_OSC_CYCLES)
  ) u_osc (
    .clk_i(clk_i),
    .rst_i(mclr),
    .run_i(osc_run),
    .tick_o(osc_tick)
  );

  // Oscillator gate state
  always_comb begin
    next_clk_state = clk_state;
    unique case (clk_state)
      BSCC_CLK_STOPPED: begin
        next_clk_state = BSCC_CLK_RUN;
      end
      BSCC_CLK_RUN: begin
        if (joint) begin
          next_clk_state = BSCC_CLK_JOINT;
        end else if ((local_mode_i && key_press_strobe_i) || hold) begin
          next_clk_state = BSCC_CLK_HOLD;
        end
      end
      BSCC_CLK_HOLD: begin
        // A press in the last held cycle retriggers the pulse, so the gate must stay held
        if (restart_end && !(local_mode_i && key_press_strobe_i)) begin
          next_clk_state = joint ? BSCC_CLK_JOINT : BSCC_CLK_RUN;
        end
      end
      BSCC_CLK_JOINT: begin
        if (!joint) begin
          next_clk_state = hold ? BSCC_CLK_HOLD : BSCC_CLK_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (mclr) begin
      clk_state <= BSCC_CLK_STOPPED;
    end else begin
      clk_state <= next_clk_state;
    end
  end

  // Key debounce hold: a later key press retriggers the restart pulse
  wire key_hit = local_mode_i && key_press_strobe_i;
  always_ff @(posedge clk_i) begin
    if (mclr) begin
      hold <= 1'b0;
      restart_cnt <= '0;
    end else if (key_hit) begin
      hold <= 1'b1;
      restart_cnt <= '0;
    end else if (restart_end) begin
      hold <= 1'b0;
      restart_cnt <= '0;
    end else if (hold) begin
      restart_cnt <= restart_cnt + RW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= processor_phase_clock_i;
    end
  end

  // Shift counter; clear beats preset, preset beats increment
  always_ff @(posedge clk_i) begin
    if (mclr || count_clear_strobe_i) begin
      count <= BSCC_COUNT_RST;
    end else if (count_preset_strobe_i) begin
      count <= instr_count_i;
    end else if (ctl_tick && count_enable_i) begin
      count <= count + 6'h01;
    end
  end

  // Jump conditions
  assign jump_o = '{
    low2_ones: &count[1:0],
    low4_ones: &count[3:0],
    low5_zero: ~|count[4:0],
    all_zero: ~|count
  };
  assign count_o = count;

  // Bit position register
  wire [4:0] bitpos_load_val = digit_mode_i ? {2'b00, shift_reg_low_i[4:2]} : shift_reg_low_i;
  always_ff @(posedge clk_i) begin
    if (mclr) begin
      bitpos <= BSCC_BITPOS_RST;
    end else if (bitpos_load_i) begin
      bitpos <= bitpos_load_val;
    end
  end
  assign bitpos_o = bitpos;

  // Digit mode forces the low two bits equal, so four bits in a row match
  wire hi3_eq = (bitpos[4:2] == count[4:2]);
  wire lo2_eq = digit_mode_i || (bitpos[1:0] == count[1:0]);
  assign bitpos_match_o = hi3_eq && lo2_eq;

  // Breakpoint comparator
  wire cmp_en = !controller_owns_processor_i;
  wire micro_low_eq = ({micro_addr_i.page, micro_addr_i.addr} == bp_reg[11:0]);
  wire micro_ws_eq = bp_condition_high || (micro_addr_i.word_sel == bp_reg[12]);
  wire micro_address_match = micro_low_eq && micro_ws_eq;
  wire macro_eq = (macro_addr_i == bp_reg[11:0]);
  wire macro_cond = (bp_cond == BSCC_BP_FETCH && instr_fetch_i) ||
                    (bp_cond == BSCC_BP_STORE && operand_store_i) ||
                    (bp_cond == BSCC_BP_ANY);
  wire micro_hit = cmp_en && micro_mode && micro_address_match && (bp_cond != BSCC_BP_OFF);
  wire macro_hit = cmp_en && !micro_mode && macro_eq && macro_cond;
  wire macro_int_set = macro_hit && bp_interrupt_instead;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      micro_stop_o <= 1'b0;
      macro_stop_o <= 1'b0;
    end else begin
      micro_stop_o <= micro_hit;
      macro_stop_o <= macro_hit && !bp_interrupt_instead;
    end
  end

  // Sticky status: a new hit wins over a software clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      macro_int <= 1'b0;
    end else if (macro_int_set) begin
      macro_int <= 1'b1;
    end else if (wr_event && wb_dat_i[BSCC_EV_MACRO_INT_POS]) begin
      macro_int <= 1'b0;
    end
  end
  assign macro_bp_interrupt_status_o = macro_int;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_clk_en_o <= 1'b0;
    end else begin
      ctl_clk_en_o <= ctl_tick;
    end
  end

  // Writable registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      function_control_register <= BSCC_FCR_RST;
      bp_reg <= BSCC_BPREG_RST;
    end else begin
      if (wr_fcr) begin
        function_control_register <= fcr_merged;
      end
      if (wr_bp) begin
        bp_reg <= bp_merged[12:0];
      end
    end
  end

  // Read mux; unmapped addresses read zero and still acknowledge
  wire [31:0] count_word = {11'h000, bitpos, 3'h0, bitpos_match_o, jump_o.all_zero, jump_o.low5_zero,
                            jump_o.low4_ones, jump_o.low2_ones, 2'h0, count};
  wire [31:0] event_word = {28'h0000000, joint, osc_run, hold, macro_int};
  always_comb begin
    unique case (wb_adr_i)
      BSCC_FCR_OFS: rdata = function_control_register;
      BSCC_BPREG_OFS: rdata = {19'h00000, bp_reg};
      BSCC_COUNT_OFS: rdata = count_word;
      BSCC_EVENT_OFS: rdata = event_word;
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack <= bus_req;
      wb_dat_o <= bus_req ? rdata : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_key_hold;
    local_mode_i && key_press_strobe_i && !master_clear_i;
  endsequence

  sequence s_held;
    hold;
  endsequence

  a_low2_jump: assert property (jump_o.low2_ones == (count[1:0] == 2'h3))
    else $error("low2 jump wrong");
  a_low4_jump: assert property (jump_o.low4_ones == (count[3:0] == 4'hf))
    else $error("low4 jump wrong");
  a_zero_jumps: assert property (jump_o.all_zero |-> jump_o.low5_zero)
    else $error("zero jumps inconsistent");
  a_count_preset: assert property (count_preset_strobe_i && !count_clear_strobe_i && !master_clear_i
                                   |=> count == $past(instr_count_i))
    else $error("count preset missed");
  a_count_clear: assert property (count_clear_strobe_i || master_clear_i |=> count == 6'h00)
    else $error("count clear missed");
  a_count_step: assert property (!count_clear_strobe_i && !count_preset_strobe_i && !master_clear_i
                                 && ctl_tick && count_enable_i |=> count == $past(count) + 6'h01)
    else $error("count step missed");
  a_count_hold: assert property (!count_clear_strobe_i && !count_preset_strobe_i && !master_clear_i
                                 && !(ctl_tick && count_enable_i) |=> $stable(count))
    else $error("count moved");
  a_bitpos_digit: assert property (bitpos_load_i && digit_mode_i && !master_clear_i
                                   |=> bitpos == {2'b00, $past(shift_reg_low_i[4:2])})
    else $error("digit position wrong");
  a_digit_match: assert property (digit_mode_i && bitpos[4:2] == count[4:2] |-> bitpos_match_o)
    else $error("digit compare wrong");
  a_owned_quiet: assert property (controller_owns_processor_i |=> !micro_stop_o && !macro_stop_o)
    else $error("break while owned");
  a_macro_int: assert property (macro_hit && bp_interrupt_instead |=> macro_int && !macro_stop_o)
    else $error("macro interrupt wrong");
  a_micro_stop: assert property (micro_hit |=> micro_stop_o)
    else $error("micro stop missed");
  a_joint_phase: assert property (joint && !phase_rise |=> !ctl_clk_en_o)
    else $error("clock leaked in joint");
  a_osc_stops: assert property (joint ##1 joint |=> !osc_run)
    else $error("oscillator ran in joint");
  a_key_hold: assert property (s_key_hold |=> s_held [*3])
    else $error("key hold too short");
  a_mclr_stop: assert property (master_clear_i |=> clk_state == BSCC_CLK_STOPPED && !hold)
    else $error("master clear did not stop");

endmodule : bscc_core

// >>> testbench/bscc_host_model.sv
`timescale 1ns/1ns
module bscc_host_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [3:0] burst_i,
  output logic phase_clk_o,
  output logic busy_o
);
  logic [3:0] left = 4'h0;
  logic [1:0] ph = 2'h0;
  // Phase clock gives one rising edge per unit and rests low between bursts
  always_ff @(posedge clk_i) begin
    if (go_i && left == 4'h0) begin
      left <= burst_i;
      ph <= 2'h0;
    end else if (left != 4'h0) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) begin
        left <= left - 4'h1;
      end
    end
  end
  assign phase_clk_o = (left != 4'h0) && ph[1];
  assign busy_o = (left != 4'h0);
endmodule : bscc_host_model

// >>> testbench/testbench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin fails++; \
  $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module testbench;
  import bscc_pkg::*;
  localparam int HOLD_CYC = 20;
  logic clk_i = 0, rst_i = 1, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, mclr = 0, pre = 0, clr = 0, ena = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'h0, burst = 4'h0;
  logic [5:0] icnt = 6'h00, count_o;
  logic [4:0] srl = 5'h00, bitpos_o;
  logic bload = 0, dmode = 0, owns = 1, fetch = 0, store = 0, local_m = 0, key = 0, go = 0;
  bscc_micro_addr_s maddr = '0;
  logic [11:0] macro_a = 12'h000;
  logic wb_ack_o, match, mstop, ustop, intst, clk_en, phase, busy;
  bscc_jump_s jump_o;
  int fails = 0, tests_run = 0, cycles = 0;
  always #50 clk_i = ~clk_i;
  bscc_host_model host (.clk_i(clk_i), .go_i(go), .burst_i(burst), .phase_clk_o(phase), .busy_o(busy));
  bscc_core #(.RESTART_CYCLES(HOLD_CYC)) uut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i),
    .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o), .master_clear_i(mclr), .count_preset_strobe_i(pre),
    .count_clear_strobe_i(clr), .count_enable_i(ena), .instr_count_i(icnt), .shift_reg_low_i(srl),
    .bitpos_load_i(bload), .digit_mode_i(dmode), .controller_owns_processor_i(owns), .micro_addr_i(maddr),
    .macro_addr_i(macro_a), .instr_fetch_i(fetch), .operand_store_i(store), .local_mode_i(local_m),
    .key_press_strobe_i(key), .processor_phase_clock_i(phase), .jump_o(jump_o), .count_o(count_o),
    .bitpos_o(bitpos_o), .bitpos_match_o(match), .macro_stop_o(mstop), .micro_stop_o(ustop),
    .macro_bp_interrupt_status_o(intst), .ctl_clk_en_o(clk_en));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask : wb

  task automatic preset(input logic [5:0] v);
    @(posedge clk_i);
    pre <= 1;
    icnt <= v;
    @(posedge clk_i);
    pre <= 0;
    tick(1);
  endtask : preset

  task automatic t_count();
    logic [5:0] vals[5] = '{6'd31, 6'd3, 6'd15, 6'd16, 6'd0};
    bscc_jump_s ej;
    foreach (vals[i]) begin
      preset(vals[i]);
      ej = '{&vals[i][1:0], &vals[i][3:0], vals[i][4:0] == 5'h00, vals[i] == 6'h00};
      `CHK("count", vals[i], count_o)
      `CHK("jump", ej, jump_o)
    end
    preset(6'd9);
    @(posedge clk_i);
    clr <= 1;
    pre <= 1;
    @(posedge clk_i);
    clr <= 0;
    pre <= 0;
    tick(1);
    `CHK("count_clr", 6'h00, count_o)
    $display("done t_count");
  endtask : t_count

  task automatic t_joint();
    int w;
    preset(6'd27);
    @(posedge clk_i);
    ena <= 1;
    tick(3);
    `CHK("clk_en_joint", 1'b0, clk_en)
    `CHK("count_hold", 6'd27, count_o)
    @(posedge clk_i);
    burst <= 4'd5;
    go <= 1;
    @(posedge clk_i);
    go <= 0;
    tick(1);
    w = 0;
    while (busy === 1'b1 && w < 100) begin
      tick(1);
      w++;
    end
    if (w >= 100) fails++;
    tick(4);
    @(posedge clk_i);
    ena <= 0;
    tick(2);
    `CHK("count_ticks", 6'd32, count_o)
    `CHK("jump_32", 4'b0010, jump_o)
    $display("done t_joint");
  endtask : t_joint

  task automatic t_bitpos();
    logic [5:0] cv[6] = '{6'h16, 6'h17, 6'h04, 6'h07, 6'h08, 6'h24};
    logic ex[6] = '{1, 0, 1, 1, 0, 1};
    foreach (cv[i]) begin
      if (i == 0 || i == 2) begin
        @(posedge clk_i);
        bload <= 1;
        dmode <= (i == 2);
        srl <= (i == 2) ? 5'h11 : 5'h16;
        @(posedge clk_i);
        bload <= 0;
        tick(1);
        `CHK("bitpos", (i == 2) ? 5'h04 : 5'h16, bitpos_o)
      end
      preset(cv[i]);
      `CHK("bit_match", ex[i], match)
    end
    @(posedge clk_i);
    dmode <= 0;
    $display("done t_bitpos");
  endtask : t_bitpos

  task automatic t_macro();
    logic exp;
    owns <= 0;
    macro_a <= 12'habc;
    wb(1, BSCC_BPREG_OFS, 32'h0000_0abc, 4'hf);
    for (int c = 0; c < 4; c++) begin
      for (int q = 0; q < 2; q++) begin
        @(posedge clk_i);
        fetch <= (q == 0);
        store <= (q == 1);
        wb(1, BSCC_FCR_OFS, c << BSCC_FCR_COND_LO, 4'hf);
        tick(2);
        exp = (c == 3) || (c == 1 && q == 0) || (c == 2 && q == 1);
        `CHK("macro_stop", exp, mstop)
      end
    end
    @(posedge clk_i);
    owns <= 1;
    tick(3);
    `CHK("stop_owned", 1'b0, mstop)
    @(posedge clk_i);
    owns <= 0;
    wb(1, BSCC_FCR_OFS, 32'h0007_0000, 4'hf);
    tick(2);
    `CHK("int_no_stop", 1'b0, mstop)
    `CHK("int_status", 1'b1, intst)
    wb(1, BSCC_EVENT_OFS, 32'h1, 4'h1);
    `CHK("int_set_wins", 1'b1, intst)
    @(posedge clk_i);
    macro_a <= 12'habd;
    wb(1, BSCC_EVENT_OFS, 32'h1, 4'h1);
    tick(1);
    `CHK("int_cleared", 1'b0, intst)
    $display("done t_macro");
  endtask : t_macro

  task automatic t_micro();
    logic [1:0] cd[5] = '{2'd1, 2'd1, 2'd2, 2'd3, 2'd0};
    logic ws[5] = '{1, 0, 0, 0, 1};
    logic ex[5] = '{1, 0, 1, 1, 0};
    @(posedge clk_i);
    maddr <= '{4'h3, 8'h5a, 1'b1};
    macro_a <= 12'h35a;
    wb(1, BSCC_BPREG_OFS, 32'h0000_135a, 4'hf);
    foreach (cd[i]) begin
      @(posedge clk_i);
      maddr.word_sel <= ws[i];
      wb(1, BSCC_FCR_OFS, 32'h0008_0000 | (cd[i] << BSCC_FCR_COND_LO), 4'hf);
      tick(2);
      `CHK("micro_stop", ex[i], ustop)
      `CHK("macro_quiet", 1'b0, mstop)
    end
    $display("done t_micro");
  endtask : t_micro

  task automatic t_clock();
    @(posedge clk_i);
    local_m <= 1;
    key <= 1;
    @(posedge clk_i);
    key <= 0;
    tick(2);
    `CHK("clk_en_hold", 1'b0, clk_en)
    wb(0, BSCC_EVENT_OFS, 32'h0, 4'hf);
    `CHK("hold_set", 1'b1, rd[BSCC_EV_HOLD_POS])
    tick(HOLD_CYC + 4);
    wb(0, BSCC_EVENT_OFS, 32'h0, 4'hf);
    `CHK("hold_done", 2'b10, rd[2:1])
    `CHK("clk_en_run", 1'b1, clk_en)
    mclr <= 1;
    tick(2);
    wb(0, BSCC_EVENT_OFS, 32'h0, 4'hf);
    `CHK("osc_mclr", 1'b0, rd[BSCC_EV_RUN_POS])
    `CHK("count_mclr", 6'h00, count_o)
    mclr <= 0;
    wb(0, 8'h40, 32'h0, 4'hf);
    `CHK("unmapped", 32'h0, rd)
    $display("done t_clock");
  endtask : t_clock

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    tick(1);
    `CHK("rst_count", BSCC_COUNT_RST, count_o)
    `CHK("rst_jump", 4'b0011, jump_o)
    t_count();
    t_joint();
    t_bitpos();
    t_macro();
    t_micro();
    t_clock();
    report_and_stop();
  end
endmodule : testbench
